// [dv/host_model.sv]
`timescale 1ns/1ps
module host_model (
  // Clock
  input  wire logic        ref_clk,
  // Device side
  input  wire logic [11:0] trialBits,
  input  wire logic [11:0] result_bits,
  input  wire logic [11:0] resultOe,
  input  wire logic [11:0] target,
  // Host side
  output logic             compHigh,
  output logic [11:0]      busVal
);
  logic [11:0] lastBus_r;
  // Keep trial while input is at or above it
  assign compHigh = (target >= trialBits);
  always_ff @(posedge ref_clk) begin
    lastBus_r <= busVal;
  end
  // Released lines flip, so a stale value never reads back
  always_comb begin
    for (int i = 0; i < 12; i++) begin
      busVal[i] = resultOe[i] ? result_bits[i] : ~lastBus_r[i];
    end
  end
endmodule

// [dv/test_sar_conversion_sequencer.sv]
`timescale 1ns/1ps
module test_sar_conversion_sequencer;
  import sar_seq_pkg::*;
  logic        ref_clk, reset, startN, upperN, lowN, compHigh, streamReady;
  logic        done, trackInput, streamValid, overrun;
  logic [11:0] resultBits, resultOe, trialBits, streamData, target, busVal;
  int          mismatches, compares;
  ////////////////////////////////////////////////////////////////////////
  sar_conversion_sequencer sar_conversion_sequencer_inst (
    .ref_clk(ref_clk), .reset(reset), .clkEn(1'b1),
    .internalClkMode(1'b1), .conversion_start_n(startN),
    .upper_byte_output_enable_n(upperN),
    .low_nibble_output_enable_n(lowN), .result_bits(resultBits),
    .resultOe(resultOe), .conversion_done_flag(done),
    .compHigh(compHigh), .trackInput(trackInput), .compBalance(),
    .trialBits(trialBits), .streamValid(streamValid),
    .streamReady(streamReady), .streamData(streamData),
    .overrun(overrun));
  host_model host_model_inst (
    .ref_clk(ref_clk), .trialBits(trialBits), .result_bits(resultBits),
    .resultOe(resultOe), .target(target), .compHigh(compHigh),
    .busVal(busVal));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [11:0] got, input logic [11:0] exp,
                       input string msg);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  // Cycles from call until done is seen rising
  task automatic wait_rise(output int n);
    n = 0;
    while (done !== 1'b0 && n < 60) begin
      @(negedge ref_clk);
      n++;
    end
    while (done !== 1'b1 && n < 60) begin
      @(negedge ref_clk);
      n++;
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic test_reset;
    check(done, 1'b0, "done after reset");
    check(resultBits, 12'h000, "result after reset");
    check(trackInput, 1'b1, "tracking after reset");
    $display("test_reset done");
  endtask
  task automatic test_freerun;
    logic [11:0] vals [4] = '{12'h000, 12'hfff, 12'ha5c, 12'h801};
    int n, trk;
    foreach (vals[k]) begin
      target = vals[k];
      wait_rise(n);
      wait_rise(n);
      check(n, 15, "cycle length");
      check(resultBits, vals[k], "converted code");
      target = ~vals[k];
      trk = trackInput;
      repeat (11) begin
        @(negedge ref_clk);
        trk += trackInput;
      end
      check(trk, 3, "tracking periods");
      check(resultBits, vals[k], "result held");
    end
    $display("test_freerun done");
  endtask
  task automatic test_enables;
    logic [11:0] exp;
    for (int c = 0; c < 4; c++) begin
      @(negedge ref_clk);
      upperN = c[1];
      lowN = c[0];
      repeat (4) @(negedge ref_clk);
      exp = {{8{~c[1]}}, {4{~c[0]}}};
      check(resultOe, exp, "enable pattern");
      check(busVal & exp, resultBits & exp, "bus value");
    end
    $display("test_enables done");
  endtask
  task automatic test_stop;
    int n;
    target = 12'h3c5;
    startN = 1'b1;
    wait_rise(n);
    wait_rise(n);
    repeat (30) @(negedge ref_clk);
    check(done, 1'b1, "done while stopped");
    check(trackInput, 1'b1, "tracking while stopped");
    startN = 1'b0;
    n = 0;
    while (done !== 1'b0 && n < 8) begin
      @(negedge ref_clk);
      n++;
    end
    check(n <= 4, 1'b1, "done falls after start");
    wait_rise(n);
    check(n, 13, "resume from period three");
    check(resultBits, 12'h3c5, "code after restart");
    $display("test_stop done");
  endtask
  task automatic test_fifo;
    int n;
    target = 12'h5a3;
    streamReady = 1'b0;
    repeat (300) @(negedge ref_clk);
    check(overrun, 1'b1, "overrun when full");
    startN = 1'b1;
    repeat (40) @(negedge ref_clk);
    streamReady = 1'b1;
    n = 0;
    repeat (30) begin
      @(negedge ref_clk);
      if (streamValid === 1'b1) begin
        n++;
        check(streamData, 12'h5a3, "stream word");
      end
    end
    check(n, 16, "words drained");
    check(streamValid, 1'b0, "stream empty");
    $display("test_fifo done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #500000;
    mismatches++;
    $display("unexpected at %0t: watchdog expired", $time);
    report_and_stop();
  end
  initial begin
    mismatches = 0;
    compares = 0;
    reset = 1'b1;
    startN = 1'b0;
    upperN = 1'b0;
    lowN = 1'b0;
    streamReady = 1'b1;
    target = 12'h000;
    repeat (20) @(negedge ref_clk);
    reset = 1'b0;
    test_reset();
    test_freerun();
    test_enables();
    test_stop();
    test_fifo();
    report_and_stop();
  end
endmodule

// [rtl/result_fifo.sv]
`timescale 1ns/1ps
module result_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic             clkEn,
  result_if.sink                inPort,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrPtr_r;
  logic [AW:0]      rdPtr_r;
  logic [WIDTH-1:0] dataOut_r;
  logic             haveOut_r;
  wire              emptyFlag = (wrPtr_r == rdPtr_r);
  wire              fullFlag  = (wrPtr_r[AW] != rdPtr_r[AW]) &&
                                (wrPtr_r[AW-1:0] == rdPtr_r[AW-1:0]);
  wire              doWrite   = clkEn && inPort.valid && !fullFlag;
  wire              outFree   = !haveOut_r || outReady;
  wire              doRead    = clkEn && !emptyFlag && outFree;

  assign inPort.ready = !fullFlag;
  assign outValid     = haveOut_r;
  assign outData      = dataOut_r;

  always_ff @(posedge ref_clk) begin
    if (doWrite) begin
      mem[wrPtr_r[AW-1:0]] <= inPort.data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wrPtr_r   <= '0;
      rdPtr_r   <= '0;
      haveOut_r <= 1'b0;
      dataOut_r <= '0;
    end else if (clkEn) begin
      if (doWrite) begin
        wrPtr_r <= wrPtr_r + 1'b1;
      end
      if (doRead) begin
        rdPtr_r   <= rdPtr_r + 1'b1;
        dataOut_r <= mem[rdPtr_r[AW-1:0]];
        haveOut_r <= 1'b1;
      end else if (outReady) begin
        haveOut_r <= 1'b0;
      end
    end
  end
endmodule

// [rtl/result_if.sv]
`timescale 1ns/1ps
interface result_if #(parameter int WIDTH = 12);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface

// [rtl/sar_conversion_sequencer.sv]
`timescale 1ns/1ps
`include "sar_seq_map.svh"
module sar_conversion_sequencer
  import sar_seq_pkg::*;
#(
  parameter int WIDTH = 12,
  parameter int DEPTH = `SAR_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic             clkEn,
  // Mode: high selects the stopping internal clock behaviour
  input  wire logic             internalClkMode,
  // Host pins
  input  wire logic             conversion_start_n,
  input  wire logic             upper_byte_output_enable_n,
  input  wire logic             low_nibble_output_enable_n,
  output logic [WIDTH-1:0]      result_bits,
  output logic [WIDTH-1:0]      resultOe,
  output logic                  conversion_done_flag,
  // Analog side
  input  wire logic             compHigh,
  output logic                  trackInput,
  output logic                  compBalance,
  output logic [WIDTH-1:0]      trialBits,
  // Result stream
  output logic                  streamValid,
  input  wire logic             streamReady,
  output logic [WIDTH-1:0]      streamData,
  output logic                  overrun
);
  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [2:0] pinMeta_r;
  logic [2:0] pinSync_r;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pinMeta_r <= 3'h7;
      pinSync_r <= 3'h7;
    end else if (clkEn) begin
      pinMeta_r <= {conversion_start_n, upper_byte_output_enable_n,
                    low_nibble_output_enable_n};
      pinSync_r <= pinMeta_r;
    end
  end
  wire startReq = !pinSync_r[2];
  wire upperEn  = !pinSync_r[1];
  wire lowEn    = !pinSync_r[0];

  ////////////////////////////////////////////////////////////////////////
  // Period sequencing
  seqState_t   state_r;
  seqState_t   state_nxt;
  logic [3:0]  period_r;
  logic [3:0]  period_nxt;
  logic        released_r;
  logic        done_r;
  logic        done_nxt;
  result_t     result_r;
  logic        ovr_r;
  wire [WIDTH-1:0] trialW;
  wire [WIDTH-1:0] decidedW;

  wire lastPeriod = (state_r == HOLD) && (period_r == `SAR_PERIODS);
  wire msbPeriod  = (state_r == HOLD) && (period_r == `SAR_MSB_PERIOD);
  wire bitPeriod  = (state_r == HOLD) && (period_r > `SAR_MSB_PERIOD);
  // Period one to two decides whether a stop is needed
  wire stopHere   = released_r && !startReq;

  always_comb begin
    state_nxt  = state_r;
    period_nxt = period_r;
    done_nxt   = done_r;
    case (state_r)
      TRACK: begin
        period_nxt = period_r + 4'h1;
        if (period_r == 4'h1) begin
          // done falls entering period two unless stopping
          if (stopHere) begin
            state_nxt = WAIT;
          end else begin
            done_nxt = 1'b0;
          end
        end else if (period_r == `SAR_TRACK_LAST) begin
          state_nxt = HOLD;
        end
      end
      WAIT: begin
        // start acted on only while waiting in period two
        if (startReq) begin
          // drop done, resume into period three
          done_nxt   = 1'b0;
          state_nxt  = TRACK;
          period_nxt = `SAR_TRACK_LAST;
        end
      end
      HOLD: begin
        if (period_r == `SAR_PERIODS) begin
          // back to tracking at period one
          state_nxt  = TRACK;
          period_nxt = 4'h1;
          // done rises at end of fifteen
          done_nxt   = 1'b1;
        end else begin
          period_nxt = period_r + 4'h1;
        end
      end
      default: begin
        state_nxt  = TRACK;
        period_nxt = 4'h1;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_r  <= TRACK;
      period_r <= 4'h1;
      done_r   <= 1'b0;
    end else if (clkEn) begin
      state_r  <= state_nxt;
      period_r <= period_nxt;
      done_r   <= done_nxt;
    end
  end

  // Start released after period fifteen; with start tied low this
  // sets only out of reset and clears by the next period one, so conversions run back to back
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      released_r <= 1'b0;
    end else if (clkEn) begin
      // free run with start low
      // With internalClkMode high not cleared at period fifteen: a release held over the cycle
      // end must still arm the stall at period one; with it low a release outside period one clears it
      if (state_r == WAIT) begin
        released_r <= 1'b0;
      end else if (!startReq) begin
        released_r <= internalClkMode ? 1'b1 : (period_r < 4'h2);
      end else if (state_r == TRACK && period_r == 4'h1) begin
        released_r <= 1'b0;
      end
    end
  end

  // The external clock case also waits in period two; the internal case
  // is modelled as the same stall since the clock here never stops
  ////////////////////////////////////////////////////////////////////////
  // Trial register
  sar_trial_reg #(.WIDTH(WIDTH)) trialReg (
    .ref_clk    (ref_clk),
    .reset      (reset),
    .clkEn      (clkEn),
    .startTrial (state_r == TRACK && period_r == `SAR_TRACK_LAST),
    .decide     (msbPeriod || bitPeriod),
    .compHigh   (compHigh),
    .trial      (trialW),
    .decided    (decidedW)
  );

  ////////////////////////////////////////////////////////////////////////
  // Output registers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      result_r <= `SAR_RESULT_RST;
    end else if (clkEn && lastPeriod) begin
      // update only at end of fifteen
      result_r <= decidedW;
    end
  end

  logic [WIDTH-1:0] oe_r;
  logic             track_r;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      oe_r       <= '0;
      track_r    <= 1'b1;
    end else if (clkEn) begin
      oe_r <= {{(WIDTH-4){upperEn}}, {4{lowEn}}};
      // track and balance in periods one to three
      track_r    <= (state_nxt != HOLD);
    end
  end

  assign result_bits          = result_r;
  assign resultOe             = oe_r;
  assign conversion_done_flag = done_r;
  assign trackInput           = track_r;
  assign compBalance          = track_r;
  // Trial word straight from the trial register, so the comparator sees
  // the trial of the current period and not the one before
  assign trialBits            = trialW;
  assign overrun              = ovr_r;

  ////////////////////////////////////////////////////////////////////////
  // Result stream; a full FIFO drops the word and flags it
  result_if #(.WIDTH(WIDTH)) fifoIn ();
  assign fifoIn.valid = clkEn && lastPeriod;
  assign fifoIn.data  = decidedW;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ovr_r <= 1'b0;
    end else if (clkEn && fifoIn.valid && !fifoIn.ready) begin
      ovr_r <= 1'b1;
    end
  end

  result_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) fifo (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .clkEn    (clkEn),
    .inPort   (fifoIn),
    .outValid (streamValid),
    .outReady (streamReady),
    .outData  (streamData)
  );

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence convEnd_s;
    lastPeriod ##1 conversion_done_flag;
  endsequence
  property doneRise_p;
    @(posedge ref_clk) disable iff (reset || !clkEn)
      lastPeriod |-> ##1 conversion_done_flag;
  endproperty
  done_rise_a : assert property (doneRise_p)
    else $error("done flag not raised after period fifteen");
  result_load_a : assert property (
    @(posedge ref_clk) disable iff (reset || !clkEn)
      lastPeriod |=> result_bits == $past(decidedW))
    else $error("result not loaded at end of cycle");
  result_hold_a : assert property (
    @(posedge ref_clk) disable iff (reset)
      !$past(lastPeriod) |-> $stable(result_bits))
    else $error("result changed mid conversion");
  period_range_a : assert property (
    @(posedge ref_clk) disable iff (reset)
      period_r >= 4'h1 && period_r <= `SAR_PERIODS)
    else $error("period out of range");
  hold_len_a : assert property (
    @(posedge ref_clk) disable iff (reset || !clkEn)
      $rose(state_r == HOLD) |-> (state_r == HOLD)[*8])
    else $error("hold interval too short");
  track_out_a : assert property (
    @(posedge ref_clk) disable iff (reset || !clkEn)
      (state_r == TRACK && period_r == 4'h2) |=> trackInput)
    else $error("input not tracked early in cycle");
  upper_oe_a : assert property (
    @(posedge ref_clk) disable iff (reset || !clkEn)
      ##1 resultOe[WIDTH-1] == $past(upperEn))
    else $error("upper enable mismatch");
  low_oe_a : assert property (
    @(posedge ref_clk) disable iff (reset || !clkEn)
      ##1 resultOe[0] == $past(lowEn))
    else $error("low enable mismatch");
  wait_start_a : assert property (
    @(posedge ref_clk) disable iff (reset || !clkEn)
      (state_r == WAIT && startReq) |=> !conversion_done_flag &&
        period_r == `SAR_TRACK_LAST)
    else $error("start did not resume conversion");
  wait_done_a : assert property (
    @(posedge ref_clk) disable iff (reset)
      state_r == WAIT |-> conversion_done_flag)
    else $error("done low while stopped");
  trial_msb_a : assert property (
    @(posedge ref_clk) disable iff (reset || !clkEn)
      (state_r == TRACK && period_r == `SAR_TRACK_LAST) |=>
        trialBits == {1'b1, {(WIDTH-1){1'b0}}})
    else $error("MSB trial not set in period four");
  stall_enter_a : assert property (
    @(posedge ref_clk) disable iff (reset || !clkEn)
      (state_r == TRACK && period_r == 4'h1 && stopHere) |=>
        state_r == WAIT && trackInput)
    else $error("sequence did not stall in period two");
endmodule

// [rtl/sar_seq_map.svh]
`ifndef SAR_SEQ_MAP_SVH
`define SAR_SEQ_MAP_SVH
`define SAR_PERIODS      4'hf
`define SAR_TRACK_LAST   4'h3
`define SAR_MSB_PERIOD   4'h4
`define SAR_WAIT_PERIOD  4'h2
`define SAR_RESULT_RST   12'h000
`define SAR_FIFO_DEPTH   16
`endif

// [rtl/sar_seq_pkg.sv]
package sar_seq_pkg;
  typedef enum logic [2:0] {
    TRACK = 3'b001,
    WAIT  = 3'b010,
    HOLD  = 3'b100
  } seqState_t;
  typedef logic [11:0] result_t;
endpackage

// [rtl/sar_trial_reg.sv]
`timescale 1ns/1ps
module sar_trial_reg #(
  parameter int WIDTH = 12
) (
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic             clkEn,
  // Control
  input  wire logic             startTrial,
  input  wire logic             decide,
  input  wire logic             compHigh,
  // Trial word
  output logic [WIDTH-1:0]      trial,
  output logic [WIDTH-1:0]      decided
);
  logic [WIDTH-1:0] trial_r;
  logic [WIDTH-1:0] pointer_r;
  wire  [WIDTH-1:0] kept    = compHigh ? trial_r : (trial_r & ~pointer_r);
  wire  [WIDTH-1:0] nextPtr = pointer_r >> 1;

  assign trial   = trial_r;
  assign decided = kept;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      trial_r   <= '0;
      pointer_r <= '0;
    end else if (clkEn) begin
      if (startTrial) begin
        trial_r   <= {1'b1, {(WIDTH-1){1'b0}}};
        pointer_r <= {1'b1, {(WIDTH-1){1'b0}}};
      end else if (decide) begin
        // keep bit, try next
        // Cleared after bit 0 so the trial word reads zero outside hold
        if (pointer_r[0]) begin
          trial_r <= '0;
        end else begin
          trial_r <= kept | nextPtr;
        end
        pointer_r <= nextPtr;
      end
    end
  end
endmodule
